/* File: core/icfp_pkg.sv */
package icfp_pkg;

  // register byte addresses on the bus
  localparam logic [11:0] ADDR_EDGE_CTRL  = 12'h000;
  localparam logic [11:0] ADDR_EXT12_CTRL = 12'h004;
  localparam logic [11:0] ADDR_FLAGS_1    = 12'h008;
  localparam logic [11:0] ADDR_FLAGS_2    = 12'h00C;

  // edge_pullup_priority_ctrl fields
  localparam int EC_PULLUP_DIS = 7;
  localparam int EC_EDGE0      = 6;
  localparam int EC_EDGE1      = 5;
  localparam int EC_EDGE2      = 4;
  localparam int EC_TMR0_PRIO  = 2;
  localparam int EC_PORT_PRIO  = 0;
  localparam logic [7:0] EC_RESET = 8'hF5;
  localparam logic [7:0] EC_MASK  = 8'hF5;

  // ext_irq12_ctrl fields
  localparam int X_IRQ2_PRIO = 7;
  localparam int X_IRQ1_PRIO = 6;
  localparam int X_IRQ2_EN   = 4;
  localparam int X_IRQ1_EN   = 3;
  localparam int X_IRQ2_FLAG = 1;
  localparam int X_IRQ1_FLAG = 0;
  localparam logic [7:0] X_RESET = 8'hC0;
  localparam logic [7:0] X_MASK  = 8'hDB;

  // periph_request_flags_1 fields
  localparam int F1_PSP    = 7;
  localparam int F1_ADC    = 6;
  localparam int F1_RX     = 5;
  localparam int F1_TX     = 4;
  localparam int F1_SSP    = 3;
  localparam int F1_CCP1   = 2;
  localparam int F1_TMR2   = 1;
  localparam int F1_TMR1   = 0;
  localparam logic [7:0] F1_RESET   = 8'h00;
  // software may set or clear the sticky bits; rx and tx are status
  localparam logic [7:0] F1_SW_MASK = 8'hCF;

  // periph_request_flags_2 fields
  localparam int F2_OSC    = 7;
  localparam int F2_CMP    = 6;
  localparam int F2_NVM    = 4;
  localparam int F2_BCOL   = 3;
  localparam int F2_VDET   = 2;
  localparam int F2_TMR3   = 1;
  localparam int F2_ECCP   = 0;
  localparam logic [7:0] F2_RESET   = 8'h00;
  localparam logic [7:0] F2_SW_MASK = 8'hDF;

  // interrupt vectors
  localparam logic [23:0] VEC_HIGH = 24'h000008;
  localparam logic [23:0] VEC_LOW  = 24'h000018;

  // capture/compare unit modes
  typedef enum logic [1:0] {
    ICFP_CC_CAPTURE = 2'b00,
    ICFP_CC_COMPARE = 2'b01,
    ICFP_CC_PWM     = 2'b10
  } icfp_cc_mode_t;

  // one-cycle event pulses from the peripherals
  typedef struct packed {
    logic psp_access;
    logic adc_done;
    logic ssp_done;
    logic ccp1_capture;
    logic ccp1_compare;
    logic tmr2_match;
    logic tmr1_ovf;
    logic osc_fail;
    logic cmp_change;
    logic nvm_write_done;
    logic bus_collision;
    logic low_voltage;
    logic tmr3_ovf;
    logic eccp_capture;
    logic eccp_compare;
  } icfp_events_t;

  // enables kept outside this block
  typedef struct packed {
    logic priority_mode_enable;
    logic global_irq_enable;
    logic global_low_enable;
    logic tmr0_enable;
    logic port_change_enable;
    logic [7:0] flags1_enable;
    logic [7:0] flags2_enable;
  } icfp_enables_t;

  typedef struct packed {
    logic [7:0]  edge_ctrl;
    logic [7:0]  ext12;
    logic [7:0]  flags1;
    logic [7:0]  flags2;
    logic [2:0]  pin_s1;
    logic [2:0]  pin_s2;
    logic [2:0]  pin_d;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq_req;
    logic [23:0] irq_vector;
    logic [7:0]  pullup_en;
  } icfp_state_t;

endpackage : icfp_pkg

/* File: core/icfp_regs.sv */
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/1ps
module icfp_regs (
  // clock and reset
  input  wire logic                   clock,
  input  wire logic                   rst,
  // apb slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [11:0]            paddr,
  input  wire logic [31:0]            pwdata,
  input  wire logic [3:0]             pstrb,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // external interrupt pins, asynchronous
  input  wire logic [2:0]             ext_irq_pin,
  // port b latches, same clock
  input  wire logic [7:0]             port_b_latch,
  // peripheral status and events, same clock
  input  wire icfp_pkg::icfp_events_t events,
  input  wire icfp_pkg::icfp_cc_mode_t capcomp1_mode,
  input  wire icfp_pkg::icfp_cc_mode_t enh_capcomp_mode,
  input  wire logic                   rx_buffer_full,
  input  wire logic                   tx_buffer_empty,
  // enables and timer0/port-change flags kept by the core
  input  wire icfp_pkg::icfp_enables_t enables,
  input  wire logic                   timer0_ovf_flag,
  input  wire logic                   port_change_flag,
  // towards the core and the port
  output logic                        ext_irq0_event,
  output logic                        irq_req,
  output logic      [23:0]            irq_vector,
  output logic      [7:0]             pullup_en,
  output logic      [7:0]             edge_ctrl_q,
  output logic      [7:0]             ext12_q,
  output logic      [7:0]             flags1_q,
  output logic      [7:0]             flags2_q
);

  icfp_pkg::icfp_state_t st_ff;
  icfp_pkg::icfp_state_t nxt_st;
  logic                  ext0_ev_ff;
  logic                  nxt_ext0_ev;

  logic       setup, access, wr, rd;
  logic [7:0] wb;
  logic [2:0] edge_sel;
  logic [2:0] edge_hit;
  logic [7:0] set1, set2;
  logic [7:0] hi_pend, lo_pend;
  logic       any_hi, any_lo, want_hi, want_lo;
  logic [7:0] prio1, prio2;

  assign setup  = psel && !penable;
  assign access = psel && penable;
  assign wr     = access && pwrite && pstrb[0];
  assign rd     = access && !pwrite;
  assign wb     = pwdata[7:0];

  assign edge_sel = {st_ff.edge_ctrl[icfp_pkg::EC_EDGE2],
                     st_ff.edge_ctrl[icfp_pkg::EC_EDGE1],
                     st_ff.edge_ctrl[icfp_pkg::EC_EDGE0]};

  // edge detect on the second synchroniser stage and its delayed copy
  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_edge
      assign edge_hit[g] = edge_sel[g] ? (st_ff.pin_s2[g] && !st_ff.pin_d[g])
                                       : (!st_ff.pin_s2[g] && st_ff.pin_d[g]);
    end
  endgenerate

  // hardware set terms, independent of any enable
  always_comb
  begin
    set1 = 8'h00;
    set2 = 8'h00;
    set1[icfp_pkg::F1_PSP]  = events.psp_access;
    set1[icfp_pkg::F1_ADC]  = events.adc_done;
    set1[icfp_pkg::F1_SSP]  = events.ssp_done;
    set1[icfp_pkg::F1_CCP1] =
      (capcomp1_mode == icfp_pkg::ICFP_CC_CAPTURE && events.ccp1_capture) ||
      (capcomp1_mode == icfp_pkg::ICFP_CC_COMPARE && events.ccp1_compare);
    set1[icfp_pkg::F1_TMR2] = events.tmr2_match;
    set1[icfp_pkg::F1_TMR1] = events.tmr1_ovf;
    set2[icfp_pkg::F2_OSC]  = events.osc_fail;
    set2[icfp_pkg::F2_CMP]  = events.cmp_change;
    set2[icfp_pkg::F2_NVM]  = events.nvm_write_done;
    set2[icfp_pkg::F2_BCOL] = events.bus_collision;
    set2[icfp_pkg::F2_VDET] = events.low_voltage;
    set2[icfp_pkg::F2_TMR3] = events.tmr3_ovf;
    set2[icfp_pkg::F2_ECCP] =
      (enh_capcomp_mode == icfp_pkg::ICFP_CC_CAPTURE && events.eccp_capture) ||
      (enh_capcomp_mode == icfp_pkg::ICFP_CC_COMPARE && events.eccp_compare);
  end

  // priority per flag bit; every bit, flags1 and flags2 alike, reads low priority
  assign prio1 = 8'h00;
  assign prio2 = 8'h00;

  // pending requests split by priority
  always_comb
  begin
    hi_pend = 8'h00;
    lo_pend = 8'h00;
    // timer0, port change, ext irq 2, ext irq 1, peripherals
    if (enables.tmr0_enable && timer0_ovf_flag)
    begin
      if (st_ff.edge_ctrl[icfp_pkg::EC_TMR0_PRIO])
        hi_pend[0] = 1'b1;
      else
        lo_pend[0] = 1'b1;
    end
    if (enables.port_change_enable && port_change_flag)
    begin
      if (st_ff.edge_ctrl[icfp_pkg::EC_PORT_PRIO])
        hi_pend[1] = 1'b1;
      else
        lo_pend[1] = 1'b1;
    end
    if (st_ff.ext12[icfp_pkg::X_IRQ2_EN] && st_ff.ext12[icfp_pkg::X_IRQ2_FLAG])
    begin
      if (st_ff.ext12[icfp_pkg::X_IRQ2_PRIO])
        hi_pend[2] = 1'b1;
      else
        lo_pend[2] = 1'b1;
    end
    if (st_ff.ext12[icfp_pkg::X_IRQ1_EN] && st_ff.ext12[icfp_pkg::X_IRQ1_FLAG])
    begin
      if (st_ff.ext12[icfp_pkg::X_IRQ1_PRIO])
        hi_pend[3] = 1'b1;
      else
        lo_pend[3] = 1'b1;
    end
    // peripheral priority bits live outside; count them as low
    lo_pend[4] = |(st_ff.flags1 & enables.flags1_enable & ~prio1);
    lo_pend[5] = |(st_ff.flags2 & enables.flags2_enable & ~prio2);
  end

  assign any_hi = |hi_pend;
  assign any_lo = |lo_pend;

  always_comb
  begin
    if (enables.priority_mode_enable)
    begin
      want_hi = any_hi && enables.global_irq_enable;
      want_lo = any_lo && enables.global_low_enable;
    end
    else
    begin
      // compatibility mode: priority bits ignored, one vector
      want_hi = enables.global_irq_enable &&
                (|hi_pend[3:0] || |lo_pend[3:0] ||
                 (enables.global_low_enable && (lo_pend[4] || lo_pend[5])));
      want_lo = 1'b0;
    end
  end

  always_comb
  begin
    nxt_st      = st_ff;
    nxt_ext0_ev = edge_hit[0];
    // two-stage pin synchroniser, then a delayed copy for edges
    nxt_st.pin_s1 = ext_irq_pin;
    nxt_st.pin_s2 = st_ff.pin_s1;
    nxt_st.pin_d  = st_ff.pin_s2;

    if (wr && paddr == icfp_pkg::ADDR_EDGE_CTRL)
      nxt_st.edge_ctrl = wb & icfp_pkg::EC_MASK;
    else if (wr && paddr == icfp_pkg::ADDR_EXT12_CTRL)
      nxt_st.ext12 = wb & icfp_pkg::X_MASK;

    // software writes of sticky flags; set wins below
    if (wr && paddr == icfp_pkg::ADDR_FLAGS_1)
      nxt_st.flags1 = (st_ff.flags1 & ~icfp_pkg::F1_SW_MASK) |
                      (wb & icfp_pkg::F1_SW_MASK);
    if (wr && paddr == icfp_pkg::ADDR_FLAGS_2)
      nxt_st.flags2 = wb & icfp_pkg::F2_SW_MASK;

    nxt_st.ext12[icfp_pkg::X_IRQ1_FLAG] = nxt_st.ext12[icfp_pkg::X_IRQ1_FLAG]
                                          | edge_hit[1];
    nxt_st.ext12[icfp_pkg::X_IRQ2_FLAG] = nxt_st.ext12[icfp_pkg::X_IRQ2_FLAG]
                                          | edge_hit[2];
    nxt_st.flags1 = nxt_st.flags1 | set1;
    nxt_st.flags2 = nxt_st.flags2 | set2;
    // read-only buffer status bits
    nxt_st.flags1[icfp_pkg::F1_RX] = rx_buffer_full;
    nxt_st.flags1[icfp_pkg::F1_TX] = tx_buffer_empty;

    // zero-wait apb: ready in the access cycle
    nxt_st.pready  = setup;
    nxt_st.pslverr = 1'b0;
    nxt_st.prdata  = 32'h0000_0000;
    if (setup)
    begin
      if (paddr == icfp_pkg::ADDR_EDGE_CTRL)
        nxt_st.prdata = {24'h000000, st_ff.edge_ctrl};
      else if (paddr == icfp_pkg::ADDR_EXT12_CTRL)
        nxt_st.prdata = {24'h000000, st_ff.ext12};
      else if (paddr == icfp_pkg::ADDR_FLAGS_1)
        nxt_st.prdata = {24'h000000, st_ff.flags1};
      else if (paddr == icfp_pkg::ADDR_FLAGS_2)
        nxt_st.prdata = {24'h000000, st_ff.flags2};
      else
        nxt_st.pslverr = 1'b1;
    end

    nxt_st.irq_req    = want_hi || want_lo;
    nxt_st.irq_vector = want_hi ? icfp_pkg::VEC_HIGH :
                        (want_lo ? icfp_pkg::VEC_LOW : st_ff.irq_vector);
    nxt_st.pullup_en = st_ff.edge_ctrl[icfp_pkg::EC_PULLUP_DIS] ? 8'h00
                                                                : port_b_latch;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      st_ff            <= '0;
      st_ff.edge_ctrl  <= icfp_pkg::EC_RESET;
      st_ff.ext12      <= icfp_pkg::X_RESET;
      st_ff.flags1     <= icfp_pkg::F1_RESET;
      st_ff.flags2     <= icfp_pkg::F2_RESET;
      st_ff.irq_vector <= icfp_pkg::VEC_HIGH;
      // keep the pin chain tracking in reset: a high pin gives no false edge
      st_ff.pin_s1     <= ext_irq_pin;
      st_ff.pin_s2     <= st_ff.pin_s1;
      st_ff.pin_d      <= st_ff.pin_s2;
      ext0_ev_ff       <= 1'b0;
    end
    else
    begin
      st_ff      <= nxt_st;
      ext0_ev_ff <= nxt_ext0_ev;
    end
  end

  assign prdata         = st_ff.prdata;
  assign pready         = st_ff.pready;
  assign pslverr        = st_ff.pslverr;
  assign irq_req        = st_ff.irq_req;
  assign irq_vector     = st_ff.irq_vector;
  assign pullup_en      = st_ff.pullup_en;
  assign ext_irq0_event = ext0_ev_ff;
  assign edge_ctrl_q    = st_ff.edge_ctrl;
  assign ext12_q        = st_ff.ext12;
  assign flags1_q       = st_ff.flags1;
  assign flags2_q       = st_ff.flags2;

  // assertions
  ext_set_wins_a: assert property (@(posedge clock) disable iff (rst)
    edge_hit[1] |=> st_ff.ext12[icfp_pkg::X_IRQ1_FLAG])
    else $error("ext irq1 edge lost");

  flag_sticky_a: assert property (@(posedge clock) disable iff (rst)
    (st_ff.flags1[icfp_pkg::F1_ADC] && !(wr && paddr == icfp_pkg::ADDR_FLAGS_1))
    |=> st_ff.flags1[icfp_pkg::F1_ADC])
    else $error("converter flag dropped without a write");

  set_beats_clear_a: assert property (@(posedge clock) disable iff (rst)
    (events.tmr3_ovf && wr && paddr == icfp_pkg::ADDR_FLAGS_2)
    |=> st_ff.flags2[icfp_pkg::F2_TMR3])
    else $error("timer3 event lost to clear");

  reserved_zero_a: assert property (@(posedge clock) disable iff (rst)
    !st_ff.edge_ctrl[3] && !st_ff.edge_ctrl[1] && !st_ff.ext12[5] &&
    !st_ff.ext12[2] && !st_ff.flags2[5])
    else $error("reserved bit set");

  pullup_off_a: assert property (@(posedge clock) disable iff (rst)
    st_ff.edge_ctrl[icfp_pkg::EC_PULLUP_DIS]
    |=> pullup_en == 8'h00)
    else $error("pull-up enabled while disabled");

  rx_mirror_a: assert property (@(posedge clock) disable iff (rst)
    rx_buffer_full |=> st_ff.flags1[icfp_pkg::F1_RX])
    else $error("receive flag not following buffer");

  compat_vec_a: assert property (@(posedge clock) disable iff (rst)
    (!enables.priority_mode_enable && want_hi)
    |=> irq_req && irq_vector == icfp_pkg::VEC_HIGH)
    else $error("compat mode vector wrong");

  pwm_no_flag_a: assert property (@(posedge clock) disable iff (rst)
    (capcomp1_mode == icfp_pkg::ICFP_CC_PWM && !st_ff.flags1[icfp_pkg::F1_CCP1]
     && !(wr && paddr == icfp_pkg::ADDR_FLAGS_1))
    |=> !st_ff.flags1[icfp_pkg::F1_CCP1])
    else $error("capcomp1 flag set in pwm mode");

endmodule : icfp_regs

/* File: sim/icfp_periph_model.sv */
`timescale 1ns/1ps
module icfp_periph_model (
  // clock
  input  wire logic                  clock,
  // requests from the bench
  input  wire logic [14:0]           ev_req,
  input  wire logic [2:0]            pin_req,
  // towards the block
  output icfp_pkg::icfp_events_t     events,
  output logic      [2:0]            ext_irq_pin
);
  // every event is a single-cycle pulse, so one request is one event
  always_ff @(posedge clock)
  begin
    events      <= icfp_pkg::icfp_events_t'(ev_req);
    ext_irq_pin <= pin_req;
  end
endmodule : icfp_periph_model

/* File: sim/icfp_regs_tb.sv */
`timescale 1ns/1ps
module icfp_regs_tb;
  // stimulus
  logic                    clock            = 1'b0;
  logic                    rst              = 1'b1;
  logic                    psel             = 1'b0;
  logic                    penable          = 1'b0;
  logic                    pwrite           = 1'b0;
  logic [11:0]             paddr            = 12'h000;
  logic [31:0]             pwdata           = 32'h0;
  logic [3:0]              pstrb            = 4'hF;
  logic [14:0]             ev_req           = 15'h0;
  logic [2:0]              pin_req          = 3'h0;
  logic [7:0]              port_b_latch     = 8'h00;
  icfp_pkg::icfp_cc_mode_t capcomp1_mode    = icfp_pkg::ICFP_CC_CAPTURE;
  icfp_pkg::icfp_cc_mode_t enh_capcomp_mode = icfp_pkg::ICFP_CC_CAPTURE;
  logic                    rx_buffer_full   = 1'b0;
  logic                    tx_buffer_empty  = 1'b0;
  icfp_pkg::icfp_enables_t enables          = '0;
  logic                    timer0_ovf_flag  = 1'b0;
  logic                    port_change_flag = 1'b0;
  // observed
  logic [31:0]             prdata;
  logic                    pready;
  logic                    pslverr;
  logic                    ext_irq0_event;
  logic                    irq_req;
  logic [23:0]             irq_vector;
  logic [7:0]              pullup_en;
  logic [7:0]              edge_ctrl_q;
  logic [7:0]              ext12_q;
  logic [7:0]              flags1_q;
  logic [7:0]              flags2_q;
  logic [2:0]              ext_irq_pin;
  icfp_pkg::icfp_events_t  events;
  // model state
  logic [31:0]             seed  = 32'hCFFF8AFB;
  logic [31:0]             rd;
  logic                    err;
  int                      failures   = 0;
  int                      num_checks = 0;
  int                      cyc        = 0;
  int                      p0         = 0;
  int                      mdl [4]    = '{8'hF5, 8'hC0, 0, 0};
  int                      msk [4]    = '{8'hF5, 8'hDB, 8'hCF, 8'hDF};
  int                      evb [15]   = '{0, 0, 1, 2, 3, 4, 6, 7,
                                          0, 1, 2, 2, 3, 6, 7};

  always #2.5 clock = ~clock;

  icfp_periph_model i_icfp_periph_model (
    .clock       (clock),
    .ev_req      (ev_req),
    .pin_req     (pin_req),
    .events      (events),
    .ext_irq_pin (ext_irq_pin)
  );

  icfp_regs i_icfp_regs (
    .clock            (clock),
    .rst              (rst),
    .psel             (psel),
    .penable          (penable),
    .pwrite           (pwrite),
    .paddr            (paddr),
    .pwdata           (pwdata),
    .pstrb            (pstrb),
    .prdata           (prdata),
    .pready           (pready),
    .pslverr          (pslverr),
    .ext_irq_pin      (ext_irq_pin),
    .port_b_latch     (port_b_latch),
    .events           (events),
    .capcomp1_mode    (capcomp1_mode),
    .enh_capcomp_mode (enh_capcomp_mode),
    .rx_buffer_full   (rx_buffer_full),
    .tx_buffer_empty  (tx_buffer_empty),
    .enables          (enables),
    .timer0_ovf_flag  (timer0_ovf_flag),
    .port_change_flag (port_change_flag),
    .ext_irq0_event   (ext_irq0_event),
    .irq_req          (irq_req),
    .irq_vector       (irq_vector),
    .pullup_en        (pullup_en),
    .edge_ctrl_q      (edge_ctrl_q),
    .ext12_q          (ext12_q),
    .flags1_q         (flags1_q),
    .flags2_q         (flags2_q)
  );

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_of_test();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_of_test

  // ev is fired in the setup cycle so it lands on the access edge
  task automatic apb(input logic wr_n, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] s,
                     input logic [14:0] ev);
    int n;
    n = 0;
    psel    <= 1'b1;
    pwrite  <= wr_n;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    ev_req  <= ev;
    @(posedge clock);
    penable <= 1'b1;
    ev_req  <= 15'h0;
    @(posedge clock);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge clock);
      n++;
    end
    if (n == 20)
      failures++;
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : apb

  task automatic wr(input int i, input logic [7:0] d);
    apb(1'b1, 12'(i * 4), {24'h0, d}, 4'hF, 15'h0);
    mdl[i] = d & msk[i];
  endtask : wr

  task automatic rdc(input int i);
    logic [7:0] st;
    logic [7:0] q;
    st = i == 2 ? {2'b00, rx_buffer_full, tx_buffer_empty, 4'h0} : 8'h00;
    apb(1'b0, 12'(i * 4), 32'h0, 4'hF, 15'h0);
    chk(rd, 32'(mdl[i]) | {24'h0, st});
    q = i == 0 ? edge_ctrl_q : (i == 1 ? ext12_q :
        (i == 2 ? flags1_q : flags2_q));
    chk(32'(q), 32'(mdl[i]) | {24'h0, st});
  endtask : rdc

  // pin path goes through a synchroniser, so give it settling margin
  task automatic pin(input int k, input logic v);
    pin_req[k] <= v;
    repeat (8) @(posedge clock);
  endtask : pin

  task automatic irq(input logic [7:0] x, input logic [7:0] e,
                     input logic [3:0] g, input logic r,
                     input logic [23:0] v);
    enables         <= '{g[3], g[2], g[1], g[0], 1'b0, 8'h00, 8'h00};
    timer0_ovf_flag <= g[0];
    wr(0, e);
    wr(1, x);
    repeat (4) @(posedge clock);
    chk(32'(irq_req), 32'(r));
    if (r)
      chk(32'(irq_vector), 32'(v));
  endtask : irq

  always @(posedge clock)
    if (ext_irq0_event === 1'b1)
      p0++;

  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      failures++;
      end_of_test();
    end
  end

  initial
  begin
    logic [7:0] d;
    int         e0;
    int         r;
    e0 = 0;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    for (int i = 0; i < 4; i++)
      rdc(i);
    chk(32'(pullup_en), 32'h0);
    for (int i = 0; i < 6; i++)
    begin
      d            = 8'(xs());
      d[7]         = i[0];
      port_b_latch <= 8'(xs());
      wr(0, d);
      rdc(0);
      chk(32'(pullup_en), d[7] ? 32'h0 : 32'(port_b_latch));
    end
    wr(1, 8'hFF);
    rdc(1);
    wr(3, 8'hFF);
    rdc(3);
    wr(1, 8'h00);
    wr(3, 8'h00);
    apb(1'b1, 12'h010, 32'hFF, 4'hF, 15'h0);
    chk(32'(err), 32'h1);
    apb(1'b0, 12'h010, 32'h0, 4'hF, 15'h0);
    chk(rd, 32'h0);
    apb(1'b1, 12'h000, 32'hFF, 4'hE, 15'h0);
    rdc(0);
    for (int k = 0; k < 3; k++)
      for (int e = 0; e < 2; e++)
      begin
        wr(0, 8'(e << (6 - k)));
        pin(k, e == 0);
        wr(1, 8'h00);
        pin(k, e == 1);
        if (k == 0)
          e0++;
        else
          mdl[1] = mdl[1] | (1 << (k - 1));
        rdc(1);
        wr(1, 8'h00);
        pin(k, e == 0);
        rdc(1);
        chk(32'(p0), 32'(e0));
      end
    for (int j = 0; j < 15; j++)
    begin
      capcomp1_mode    <= j == 11 ? icfp_pkg::ICFP_CC_CAPTURE
                                  : icfp_pkg::ICFP_CC_COMPARE;
      enh_capcomp_mode <= j == 1 ? icfp_pkg::ICFP_CC_CAPTURE
                                 : icfp_pkg::ICFP_CC_COMPARE;
      apb(1'b0, 12'h000, 32'h0, 4'hF, 15'(1 << j));
      r      = j < 8 ? 3 : 2;
      mdl[r] = mdl[r] | (1 << evb[j]);
      rdc(r);
      rdc(r);
      wr(r, 8'h00);
      rdc(r);
    end
    capcomp1_mode    <= icfp_pkg::ICFP_CC_PWM;
    enh_capcomp_mode <= icfp_pkg::ICFP_CC_PWM;
    apb(1'b0, 12'h000, 32'h0, 4'hF, 15'h0C03);
    rdc(2);
    rdc(3);
    apb(1'b0, 12'h000, 32'h0, 4'hF, 15'h0100);
    apb(1'b1, 12'h008, 32'h0, 4'hF, 15'h0100);
    mdl[2] = 1;
    rdc(2);
    wr(2, 8'h00);
    rx_buffer_full  <= 1'b1;
    tx_buffer_empty <= 1'b1;
    wr(2, 8'h00);
    rdc(2);
    rx_buffer_full  <= 1'b0;
    tx_buffer_empty <= 1'b0;
    wr(2, 8'h30);
    rdc(2);
    irq(8'h09, 8'h00, 4'b0100, 1'b1, icfp_pkg::VEC_HIGH);
    irq(8'h09, 8'h00, 4'b1100, 1'b0, icfp_pkg::VEC_HIGH);
    irq(8'h09, 8'h00, 4'b1010, 1'b1, icfp_pkg::VEC_LOW);
    irq(8'h49, 8'h00, 4'b1100, 1'b1, icfp_pkg::VEC_HIGH);
    irq(8'h41, 8'h00, 4'b1110, 1'b0, icfp_pkg::VEC_HIGH);
    irq(8'h00, 8'h00, 4'b1011, 1'b1, icfp_pkg::VEC_LOW);
    irq(8'h00, 8'h04, 4'b1101, 1'b1, icfp_pkg::VEC_HIGH);
    end_of_test();
  end
endmodule : icfp_regs_tb
